// ### core/fdcr_regs.sv
// tape assignment, main status and rate/precomp/power registers behind an ahb-lite slave
// How it works
// - tape field picks none or drive 1..3
// - drive 0 never gets tape support
// - upper tape bits ignored, read as zero
// - referenced tape drive runs separator in tape mode
// - soft reset keeps tape field
// - status register readable any time, no delay
// - status reads 00 until ready, then 80
// - request bit clears after each data byte
// - non-dma execution: request bit mirrors interrupt
// - direction bit: 0 host writes, 1 reads
// - bit 5 shows non-dma execution phase
// - command bit spans first byte to end
// - drive busy bits: seek sets, sense clears
// - rate register write-only; latest rate write wins
// - hard reset loads 02, soft keeps it
// - bit 7 pulses a self-clearing soft reset
// - bit 6 enters manual sleep
// - soft reset or data/status access wakes
// - rate code decode, fm halves, 11 illegal in fm
// - shift code decode with rate default
// - output-register reset bit holds reset while low
`timescale 1ns/10ps
module fdcr_regs
   import fdcr_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic digital_output_reg_reset,
   input wire logic config_control_reg_wr,
   input wire logic [1:0] config_control_reg_rate,
   input wire logic fm_mode,
   input wire logic data_xfer,
   input wire logic eng_ready,
   input wire logic eng_read_dir,
   input wire logic nondma_exec,
   input wire logic int_pin,
   input wire logic cmd_first_wr,
   input wire logic cmd_end,
   input wire logic [3:0] seek_start,
   input wire logic [3:0] sense_read,
   input wire logic [1:0] drive_ref,
   output logic tape_mode,
   output logic [1:0] tape_unit,
   output logic soft_reset,
   output logic osc_enable,
   output logic manual_sleep,
   output logic [1:0] bit_rate_sel,
   output logic [10:0] rate_kbps,
   output logic rate_illegal,
   output logic [2:0] write_shift_sel,
   output logic [11:0] shift_tenth_ns
);

   // offsets up to 0x008 need 4 address bits; the start-up counter is only 9 bits wide
   if (ADDR_W < 4 || ADDR_W > 12 || INIT_CYC > 512)
   begin : g_bad_param
      $error("fdcr_regs: ADDR_W must lie between 4 and 12 and the start-up count fit 9 bits");
   end

   // bus side state
   logic wr_pend_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [31:0] hrdata_q;

   // register state
   logic [1:0] tape_q;
   logic [1:0] rate_q;
   logic [2:0] shift_q;
   logic sw_pulse_q;
   fdcr_init_e state_q;
   fdcr_init_e state_d;
   logic [8:0] init_cnt_q;
   logic req_q;
   logic tape_mode_q;
   logic [10:0] kbps_q;
   logic illegal_q;
   logic [11:0] shift_ns_q;
   logic cmd_flag;
   logic [3:0] busy_flag;

   // decode
   wire addr_phase = hsel & htrans[1] & hready;
   wire [11:0] ap_ofs = 12'(haddr);
   wire [11:0] dp_ofs = 12'(wr_addr_q);
   wire wr_tape = wr_pend_q & (dp_ofs == OFS_TAPE);
   wire wr_rate = wr_pend_q & (dp_ofs == OFS_RATE);
   wire stat_rd = addr_phase & ~hwrite & (ap_ofs == OFS_STAT);
   wire swrst_req = wr_rate & hwdata[SWRST_BIT];
   wire sleep_req = wr_rate & hwdata[SLEEP_BIT];
   wire srst = sw_pulse_q | ~digital_output_reg_reset;
   wire ready = (state_q == ST_READY);
   wire wake = srst | data_xfer | stat_rd;
   wire init_done = (init_cnt_q == 9'(INIT_CYC - 1));

   // status byte, zero while starting up or asleep
   wire host_request_flag = nondma_exec ? int_pin : req_q;
   wire [7:0] stat_live = {host_request_flag, eng_read_dir, nondma_exec, cmd_flag, busy_flag};
   wire [7:0] stat_val = ready ? stat_live : STAT_IDLE;

   // read mux: reserved tape bits and the write-only register read as zero,
   // since the bus cannot float single bits
   wire [31:0] rd_tape = {30'h0, tape_q};
   wire [31:0] rd_stat = {24'h00_0000, stat_val};
   wire [31:0] rd_mux = (ap_ofs == OFS_TAPE) ? rd_tape : ((ap_ofs == OFS_STAT) ? rd_stat : 32'h0000_0000);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // address phase latch; hsize is not checked, only word transfers are used
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= addr_phase & hwrite;
         wr_addr_q <= addr_phase ? haddr : wr_addr_q;
         hrdata_q <= (addr_phase & ~hwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // tape assignment survives soft reset, only hard reset clears it
   always_ff @(posedge clk)
   begin
      if (!nrst)
         tape_q <= TAPE_RST;
      else if (wr_tape)
         tape_q <= hwdata[1:0];
   end

   // data rate follows whichever of the two registers was written last
   always_ff @(posedge clk)
   begin
      if (!nrst)
         rate_q <= RATE_RST;
      else if (wr_rate)
         rate_q <= hwdata[RATE_LSB +: 2];
      else if (config_control_reg_wr)
         rate_q <= config_control_reg_rate;
   end

   // bit 5 is dropped on write, bit 7 never stored
   always_ff @(posedge clk)
   begin
      if (!nrst)
         shift_q <= SHIFT_RST;
      else if (wr_rate)
         shift_q <= hwdata[SHIFT_LSB +: 3];
   end

   // one-cycle self-clearing soft reset
   always_ff @(posedge clk)
   begin
      if (!nrst)
         sw_pulse_q <= 1'b0;
      else
         sw_pulse_q <= swrst_req;
   end

   // soft reset is the pulse or the output-register bit held low
   assign soft_reset = srst;

   // start-up sequencer: counts oscillator settle, then reports ready
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_WAIT:
         begin
            if (sleep_req)
               state_d = ST_SLEEP;
            else if (init_done)
               state_d = ST_READY;
         end
         ST_READY:
         begin
            if (sleep_req)
               state_d = ST_SLEEP;
            else if (srst)
               state_d = ST_WAIT;
         end
         ST_SLEEP:
         begin
            if (wake)
               state_d = ST_WAIT;
         end
         default:
            state_d = ST_WAIT;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         state_q <= ST_WAIT;
      else
         state_q <= state_d;
   end

   // counter restarts whenever the sequencer is not waiting, so every wait is full length
   always_ff @(posedge clk)
   begin
      if (!nrst)
         init_cnt_q <= 9'h000;
      else if (state_q != ST_WAIT || srst)
         init_cnt_q <= 9'h000;
      else if (!init_done)
         init_cnt_q <= init_cnt_q + 9'h001;
   end

   assign osc_enable = (state_q != ST_SLEEP);
   assign manual_sleep = (state_q == ST_SLEEP);

   // request bit drops after each data byte and returns when the engine is ready
   always_ff @(posedge clk)
   begin
      if (!nrst)
         req_q <= 1'b0;
      else if (srst || data_xfer)
         req_q <= 1'b0;
      else
         req_q <= eng_ready;
   end

   // command-in-progress flag
   fdcr_flag u_cmd_flag
   (
      .clk(clk),
      .nrst(nrst),
      .set(cmd_first_wr),
      .clr(cmd_end | srst),
      .q(cmd_flag)
   );

   // per-drive seek busy flags
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_busy
         fdcr_flag u_busy
         (
            .clk(clk),
            .nrst(nrst),
            .set(seek_start[i]),
            .clr(sense_read[i] | srst),
            .q(busy_flag[i])
         );
      end
   endgenerate

   // tape mode for the drive being referenced; code 0 and drive 0 never match
   wire tape_hit = (tape_q != 2'h0) & (drive_ref == tape_q);

   // rate decode, fm halves the mfm figure
   logic [10:0] kbps_mfm;
   always_comb
   begin
      case (rate_q)
         RATE_1M: kbps_mfm = KBPS_1M;
         RATE_500K: kbps_mfm = KBPS_500K;
         RATE_300K: kbps_mfm = KBPS_300K;
         RATE_250K: kbps_mfm = KBPS_250K;
         default: kbps_mfm = KBPS_250K;
      endcase
   end
   wire [10:0] kbps_d = fm_mode ? (kbps_mfm >> 1) : kbps_mfm;
   wire illegal_d = fm_mode & (rate_q == RATE_1M);

   // shift decode, code 0 takes the rate-dependent default
   logic [11:0] shift_d;
   always_comb
   begin
      case (shift_q)
         3'h7: shift_d = SHIFT_000;
         3'h1: shift_d = SHIFT_417;
         3'h2: shift_d = SHIFT_833;
         3'h3: shift_d = SHIFT_1250;
         3'h4: shift_d = SHIFT_1667;
         3'h5: shift_d = SHIFT_2083;
         3'h6: shift_d = SHIFT_2500;
         SHIFT_DEFAULT: shift_d = (rate_q == RATE_1M) ? SHIFT_417 : SHIFT_1250;
         default: shift_d = SHIFT_1250;
      endcase
   end

   // decoded outputs are registered, one cycle behind the fields
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         tape_mode_q <= 1'b0;
         kbps_q <= KBPS_250K;
         illegal_q <= 1'b0;
         shift_ns_q <= SHIFT_1250;
      end
      else
      begin
         tape_mode_q <= tape_hit;
         kbps_q <= kbps_d;
         illegal_q <= illegal_d;
         shift_ns_q <= shift_d;
      end
   end

   assign tape_mode = tape_mode_q;
   assign tape_unit = tape_q;
   assign bit_rate_sel = rate_q;
   assign rate_kbps = kbps_q;
   assign rate_illegal = illegal_q;
   assign write_shift_sel = shift_q;
   assign shift_tenth_ns = shift_ns_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_tape_not_zero: assert property (tape_mode_q |-> $past(drive_ref) != 2'h0 && $past(drive_ref) == $past(tape_q))
      else $error("tape mode given to an unassigned drive");

   a_tape_kept: assert property (srst && !wr_tape |=> $stable(tape_q))
      else $error("tape field changed on soft reset");

   a_stat_idle: assert property (stat_rd && !ready |=> hrdata_q == 32'h0000_0000)
      else $error("status not zero while starting up");

   a_stat_ready: assert property ($fell(srst) |-> ##[0:252] (state_q != ST_WAIT))
      else $error("status not ready in time");

   a_req_drop: assert property (data_xfer |=> !req_q)
      else $error("request bit did not drop after a byte");

   a_req_int: assert property (stat_rd && ready && nondma_exec |=> hrdata_q[STAT_REQ_BIT] == $past(int_pin))
      else $error("request bit not following interrupt");

   a_busy_set: assert property (|seek_start |=> (busy_flag & $past(seek_start)) == $past(seek_start))
      else $error("busy bit not set by seek");

   a_rate_cfg: assert property (config_control_reg_wr && !wr_rate |=>
      rate_q == $past(config_control_reg_rate))
      else $error("rate not taken from config write");

   a_swrst_self: assert property (swrst_req |=> soft_reset ##1 (!sw_pulse_q || $past(swrst_req)))
      else $error("soft reset did not clear itself");

   a_sleep_wake: assert property (state_q == ST_SLEEP && wake |=> state_q == ST_WAIT)
      else $error("sleep not left on access");

endmodule // fdcr_regs

// ### core/fdcr_pkg.sv
// constants, offsets and types shared by the floppy controller register bank
package fdcr_pkg;

   // register byte offsets on the bus
   localparam logic [11:0] OFS_TAPE = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_RATE = 12'h008;

   // reset values
   localparam logic [1:0] TAPE_RST = 2'h0;
   localparam logic [1:0] RATE_RST = 2'h2;
   localparam logic [2:0] SHIFT_RST = 3'h0;
   localparam logic [7:0] STAT_IDLE = 8'h00;

   // rate/precomp/power register field positions
   localparam int RATE_LSB = 0;
   localparam int SHIFT_LSB = 2;
   localparam int SLEEP_BIT = 6;
   localparam int SWRST_BIT = 7;

   // main status bit positions
   localparam int STAT_REQ_BIT = 7;
   localparam int STAT_DIR_BIT = 6;
   localparam int STAT_NONDMA_BIT = 5;
   localparam int STAT_CMD_BIT = 4;

   // start-up time before the status register may report ready
   localparam int CLK_NS = 10;
   localparam int INIT_NS = 2500;
   localparam int INIT_CYC = (INIT_NS / CLK_NS) < 1 ? 1 : (INIT_NS / CLK_NS);

   // data-rate codes and rates in kb/s (mfm)
   localparam logic [1:0] RATE_1M = 2'h3;
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [10:0] KBPS_1M = 11'h3E8;
   localparam logic [10:0] KBPS_500K = 11'h1F4;
   localparam logic [10:0] KBPS_300K = 11'h12C;
   localparam logic [10:0] KBPS_250K = 11'h0FA;

   // write shift codes and delays in tenths of a nanosecond
   localparam logic [2:0] SHIFT_DEFAULT = 3'h0;
   localparam logic [11:0] SHIFT_000 = 12'h000;
   localparam logic [11:0] SHIFT_417 = 12'h1A1;
   localparam logic [11:0] SHIFT_833 = 12'h341;
   localparam logic [11:0] SHIFT_1250 = 12'h4E2;
   localparam logic [11:0] SHIFT_1667 = 12'h683;
   localparam logic [11:0] SHIFT_2083 = 12'h823;
   localparam logic [11:0] SHIFT_2500 = 12'h9C4;

   // start-up sequencer
   typedef enum logic [2:0]
   {
      ST_WAIT = 3'b001,
      ST_READY = 3'b010,
      ST_SLEEP = 3'b100
   } fdcr_init_e;

endpackage

// ### core/fdcr_flag.sv
// sticky status flag where a set always wins over a clear
`timescale 1ns/10ps
module fdcr_flag
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   logic flag_q;
   logic flag_d;

   assign flag_d = set ? 1'b1 : (clr ? 1'b0 : flag_q);
   assign q = flag_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end

   a_flag_set_wins: assert property (@(posedge clk) disable iff (!nrst) set |=> flag_q)
      else $error("flag lost a set that met a clear");

endmodule // fdcr_flag

// ### testbench/fdcr_host.sv
// host bus master model issuing single ahb-lite word transfers
`timescale 1ns/10ps
module fdcr_host
(
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // no latency assumed: both phases wait on hready; the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      // reads leave write data toggling so a stale value never looks valid
      hwdata <= w ? d : ~hwdata;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
endmodule // fdcr_host

// ### testbench/tb.sv
// self-checking bench for the floppy controller register bank
`timescale 1ns/10ps
module tb;
   import fdcr_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel, hwrite, hready, hresp;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic digital_output_reg_reset = 1'b1, config_control_reg_wr = 1'b0, fm_mode = 1'b0, data_xfer = 1'b0;
   logic eng_ready = 1'b1, eng_read_dir = 1'b0, nondma_exec = 1'b0, int_pin = 1'b0, cmd_first_wr = 1'b0;
   logic cmd_end = 1'b0;
   logic [1:0] config_control_reg_rate = 2'h0, drive_ref = 2'h0, tape_unit, bit_rate_sel;
   logic [3:0] seek_start = 4'h0, sense_read = 4'h0;
   logic tape_mode, soft_reset, osc_enable, manual_sleep, rate_illegal;
   logic [10:0] rate_kbps;
   logic [2:0] write_shift_sel;
   logic [11:0] shift_tenth_ns;
   int err_count = 0;
   int checks_done = 0;

   always #5 clk = ~clk;

   fdcr_host host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   fdcr_regs uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .digital_output_reg_reset(digital_output_reg_reset), .config_control_reg_wr(config_control_reg_wr),
      .config_control_reg_rate(config_control_reg_rate), .fm_mode(fm_mode),
      .data_xfer(data_xfer), .eng_ready(eng_ready), .eng_read_dir(eng_read_dir), .nondma_exec(nondma_exec),
      .int_pin(int_pin), .cmd_first_wr(cmd_first_wr), .cmd_end(cmd_end), .seek_start(seek_start),
      .sense_read(sense_read), .drive_ref(drive_ref), .tape_mode(tape_mode), .tape_unit(tape_unit),
      .soft_reset(soft_reset), .osc_enable(osc_enable), .manual_sleep(manual_sleep),
      .bit_rate_sel(bit_rate_sel), .rate_kbps(rate_kbps), .rate_illegal(rate_illegal),
      .write_shift_sel(write_shift_sel), .shift_tenth_ns(shift_tenth_ns));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      host.xfer(1'b1, a, {24'h000000, d}, r);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      host.xfer(1'b0, a, 32'h0000_0000, r);
   endtask

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #100000;
      err_count++;
      stop_test();
   end

   initial
   begin
      logic [31:0] r;
      int i;
      logic [10:0] kb [4];
      logic [11:0] sh [4];
      kb = '{KBPS_500K, KBPS_300K, KBPS_250K, KBPS_1M};
      sh = '{SHIFT_1250, SHIFT_417, SHIFT_833, SHIFT_1250};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_STAT, r);
      chk(r, {24'h000000, STAT_IDLE});
      chk({hresp, hready}, 2'b01);
      chk({tape_unit, bit_rate_sel, write_shift_sel}, {TAPE_RST, RATE_RST, SHIFT_RST});
      chk(rate_kbps, KBPS_250K);
      tick(260);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0080);
      $display("reset test done");
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_TAPE, 8'hFC | 8'(i));
         rd(OFS_TAPE, r);
         chk(r, 32'(i));
         @(posedge clk);
         drive_ref <= 2'(i);
         tick(2);
         chk(tape_mode, i != 0);
         @(posedge clk);
         drive_ref <= 2'(i + 1);
         tick(2);
         chk(tape_mode, 1'b0);
      end
      $display("tape test done");
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_RATE, 8'(i * 5));
         tick(2);
         chk({bit_rate_sel, write_shift_sel}, {2'(i), 3'(i)});
         chk(rate_kbps, kb[i]);
         chk(shift_tenth_ns, sh[i]);
      end
      // bit 5 set on purpose: it must not leak into the shift or rate fields
      wr(OFS_RATE, 8'h3D);
      rd(OFS_RATE, r);
      chk(r, 32'h0000_0000);
      @(posedge clk);
      fm_mode <= 1'b1;
      tick(2);
      chk({bit_rate_sel, write_shift_sel, shift_tenth_ns}, {2'h1, 3'h7, SHIFT_000});
      chk(rate_kbps, KBPS_300K >> 1);
      @(posedge clk);
      config_control_reg_wr <= 1'b1;
      config_control_reg_rate <= 2'h3;
      @(posedge clk);
      config_control_reg_wr <= 1'b0;
      tick(2);
      chk({bit_rate_sel, rate_illegal}, 3'b111);
      @(posedge clk);
      fm_mode <= 1'b0;
      tick(2);
      chk({bit_rate_sel, rate_illegal}, 3'b110);
      chk(rate_kbps, KBPS_1M);
      wr(OFS_RATE, 8'h0F);
      $display("rate test done");
      @(posedge clk);
      eng_read_dir <= 1'b1;
      nondma_exec <= 1'b1;
      cmd_first_wr <= 1'b1;
      seek_start <= 4'hA;
      @(posedge clk);
      cmd_first_wr <= 1'b0;
      seek_start <= 4'h0;
      rd(OFS_STAT, r);
      chk(r, 32'h0000_007A);
      @(posedge clk);
      int_pin <= 1'b1;
      rd(OFS_STAT, r);
      chk(r, 32'h0000_00FA);
      @(posedge clk);
      int_pin <= 1'b0;
      nondma_exec <= 1'b0;
      eng_read_dir <= 1'b0;
      cmd_end <= 1'b1;
      sense_read <= 4'h2;
      @(posedge clk);
      cmd_end <= 1'b0;
      sense_read <= 4'h0;
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0088);
      eng_ready <= 1'b0;
      data_xfer <= 1'b1;
      @(posedge clk);
      data_xfer <= 1'b0;
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0008);
      eng_ready <= 1'b1;
      tick(2);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0088);
      $display("status test done");
      wr(OFS_RATE, 8'h8F);
      #1;
      chk(soft_reset, 1'b1);
      tick(1);
      chk(soft_reset, 1'b0);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0000);
      chk({tape_unit, bit_rate_sel, write_shift_sel}, 7'h7B);
      tick(260);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0080);
      @(posedge clk);
      digital_output_reg_reset <= 1'b0;
      tick(3);
      chk(soft_reset, 1'b1);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0000);
      digital_output_reg_reset <= 1'b1;
      tick(260);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0080);
      $display("soft reset test done");
      wr(OFS_RATE, 8'h4F);
      tick(2);
      chk({manual_sleep, osc_enable, bit_rate_sel}, 4'hB);
      rd(OFS_STAT, r);
      tick(2);
      chk({manual_sleep, osc_enable}, 2'b01);
      chk(r, 32'h0000_0000);
      wr(OFS_RATE, 8'h4F);
      tick(2);
      chk(manual_sleep, 1'b1);
      @(posedge clk);
      data_xfer <= 1'b1;
      @(posedge clk);
      data_xfer <= 1'b0;
      tick(2);
      chk({manual_sleep, osc_enable}, 2'b01);
      $display("sleep test done");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      tick(1);
      chk({tape_unit, bit_rate_sel, write_shift_sel}, {TAPE_RST, RATE_RST, SHIFT_RST});
      chk(rate_kbps, KBPS_250K);
      rd(OFS_STAT, r);
      chk(r, 32'h0000_0000);
      $display("hard reset test done");
      stop_test();
   end
endmodule // tb
